// ---- inc/sccu_pkg.sv ----
package sccu_pkg;

  // ==========================================================
  // Sizes
  localparam int SCCU_NCH = 16;
  localparam int SCCU_AW = 8;
  localparam int SCCU_TW = 16;
  localparam int SCCU_PRE_W = 4;
  localparam int SCCU_STAG_W = 3;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] SCCU_CTRL = 8'h00;
  localparam logic [7:0] SCCU_TMR0 = 8'h04;
  localparam logic [7:0] SCCU_RLD0 = 8'h08;
  localparam logic [7:0] SCCU_TMR1 = 8'h0c;
  localparam logic [7:0] SCCU_RLD1 = 8'h10;
  localparam logic [7:0] SCCU_STAT = 8'h14;
  localparam logic [7:0] SCCU_MASK = 8'h18;
  localparam logic [7:0] SCCU_PINS = 8'h1c;
  localparam logic [7:0] SCCU_LAST_CORE = 8'h1f;
  localparam logic [1:0] SCCU_PAGE_VAL = 2'h1;
  localparam logic [1:0] SCCU_PAGE_CFG = 2'h2;

  // ==========================================================
  // Control register fields
  localparam int SCCU_CTRL_RUN0 = 0;
  localparam int SCCU_CTRL_RUN1 = 1;
  localparam int SCCU_CTRL_SEL0 = 2;
  localparam int SCCU_SEL_W = 3;
  localparam int SCCU_CTRL_STAG = 8;
  localparam int SCCU_CTRL_W = 9;
  localparam logic [SCCU_CTRL_W-1:0] SCCU_CTRL_RST = 9'h000;
  localparam logic [SCCU_TW-1:0] SCCU_RLD_RST = 16'h0000;
  localparam logic [SCCU_TW-1:0] SCCU_TMR_MAX = 16'hffff;

  // Count clock selection: codes up to SCCU_CLK_MAXDIV divide by 2**code
  localparam logic [2:0] SCCU_CLK_MAXDIV = 3'h4;
  localparam logic [2:0] SCCU_CLK_EXT_OVF = 3'h5;
  localparam logic [2:0] SCCU_CLK_EXT_IN = 3'h6;

  // ==========================================================
  // Status bits: one per channel, then the two timer overflows
  localparam int SCCU_ST_OVF0 = 16;
  localparam int SCCU_ST_W = 18;

  // ==========================================================
  // Channel configuration
  typedef enum logic [2:0] {
    SCCU_OFF,
    SCCU_CAP,
    SCCU_CMP0,
    SCCU_CMP1,
    SCCU_CMP2,
    SCCU_CMP3,
    SCCU_DBL
  } sccu_mode_t;

  typedef struct packed {
    logic single;
    logic tsel;
    logic [1:0] edge_sel;
    sccu_mode_t mode;
  } sccu_cfg_t;

  localparam int SCCU_CFG_W = 7;
  localparam int SCCU_EDGE_RISE = 0;
  localparam int SCCU_EDGE_FALL = 1;
  localparam int SCCU_PAIR = 8;

  // ==========================================================
  // Bus answers
  localparam logic [1:0] SCCU_OKAY = 2'h0;
  localparam logic [1:0] SCCU_SLVERR = 2'h2;

endpackage : sccu_pkg

// ---- src/sccu_top.sv ----
`timescale 1ns/1ps

// Overview of operation
// - Sixteen channels, one-cycle resolution; staggered option services one channel in eight per cycle.
// - Two independent 16-bit timers, each with its own reload register.
// - Timer count clock: prescaled system clock, external overflow pulse, or external count input.
// - Every channel picks either timer and capture or compare function independently.
// - Each channel owns one pin: trigger input when capturing, output in compare modes 1 and 3 and in double register mode.
// - A capture edge on the pin copies the allocated timer into the channel register.
// - Each capture raises that channel's own interrupt request.
// - Capture edge per channel: rising, falling, or both.
// - Compare channels match their timer every cycle (one cycle in eight when staggered) and act per selected mode.
// - Mode 0: interrupt only, pin untouched, many matches per period.
// - Mode 1: pin inverts on every match, many per period.
// - Mode 2: interrupt only, at most one per timer period.
// - Mode 3: pin high on match, low on timer overflow, once per period.
// - Double register mode: two registers toggle one pin, either match toggles.
// - Single event option stops a channel after its first compare event.
module sccu_top (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [sccu_pkg::SCCU_AW-1:0] awaddr,
  input wire logic [2:0] awprot,
  // AXI4-Lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [sccu_pkg::SCCU_AW-1:0] araddr,
  input wire logic [2:0] arprot,
  // AXI4-Lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Channel pins
  input wire logic [sccu_pkg::SCCU_NCH-1:0] cc_pin_i,
  output logic [sccu_pkg::SCCU_NCH-1:0] cc_pin_o,
  output logic [sccu_pkg::SCCU_NCH-1:0] cc_pin_oe,
  // External count sources
  input wire logic ext_ovf_i,
  input wire logic [1:0] ext_cnt_i,
  // Interrupt
  output logic irq
);
  import sccu_pkg::*;

  // ==========================================================
  // Decode helpers
  function automatic logic is_val(input logic [SCCU_AW-1:0] a);
    return a[7:6] == SCCU_PAGE_VAL;
  endfunction : is_val

  function automatic logic is_cfg(input logic [SCCU_AW-1:0] a);
    return a[7:6] == SCCU_PAGE_CFG;
  endfunction : is_cfg

  function automatic logic map_ok(input logic [SCCU_AW-1:0] a);
    return (a <= SCCU_LAST_CORE) || is_val(a) || is_cfg(a);
  endfunction : map_ok

  function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction : strb_merge

  // ==========================================================
  // State
  logic aw_got_q;
  logic w_got_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic [SCCU_AW-1:0] waddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [31:0] rdata_q;
  logic [31:0] rd_d;
  logic rd_ok;

  logic [SCCU_CTRL_W-1:0] ctrl_q;
  logic [SCCU_TW-1:0] tmr_q [2];
  logic [SCCU_TW-1:0] rld_q [2];
  logic [SCCU_PRE_W-1:0] pre_q;
  logic [1:0] ecnt_prev_q;
  logic [SCCU_STAG_W-1:0] stag_q;
  logic [SCCU_ST_W-1:0] st_q;
  logic [SCCU_ST_W-1:0] mask_q;

  logic [SCCU_TW-1:0] val_q [SCCU_NCH];
  sccu_cfg_t cfg_q [SCCU_NCH];
  logic pin_q [SCCU_NCH];
  logic done_q [SCCU_NCH];
  logic prev_q [SCCU_NCH];

  logic [1:0] tick;
  logic [1:0] ovf;
  logic [SCCU_NCH-1:0] ch_ev;

  // ==========================================================
  // AXI4-Lite slave: address and data taken in either order
  wire wr_fire = aw_got_q && w_got_q && !bvalid_q;
  wire wr_ctrl = wr_fire && (waddr_q == SCCU_CTRL);
  wire wr_stat = wr_fire && (waddr_q == SCCU_STAT);
  wire wr_mask = wr_fire && (waddr_q == SCCU_MASK);
  wire [1:0] wr_tmr = {wr_fire && (waddr_q == SCCU_TMR1), wr_fire && (waddr_q == SCCU_TMR0)};
  wire [1:0] wr_rld = {wr_fire && (waddr_q == SCCU_RLD1), wr_fire && (waddr_q == SCCU_RLD0)};
  wire wr_val_pg = wr_fire && is_val(waddr_q);
  wire wr_cfg_pg = wr_fire && is_cfg(waddr_q);
  wire [3:0] widx = waddr_q[5:2];

  assign awready = !aw_got_q && !bvalid_q;
  assign wready = !w_got_q && !bvalid_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = !rvalid_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= SCCU_OKAY;
      waddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else begin
      if (awvalid && awready) begin
        aw_got_q <= 1'b1;
        waddr_q <= awaddr;
      end
      if (wvalid && wready) begin
        w_got_q <= 1'b1;
        wdata_q <= wdata;
        wstrb_q <= wstrb;
      end
      if (wr_fire) begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= map_ok(waddr_q) ? SCCU_OKAY : SCCU_SLVERR;
      end else if (bvalid_q && bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Read data is registered at the address handshake
  always_comb begin
    rd_d = '0;
    rd_ok = 1'b1;
    if (is_val(araddr)) begin
      rd_d = {16'h0000, val_q[araddr[5:2]]};
    end else if (is_cfg(araddr)) begin
      rd_d = {25'h0000000, cfg_q[araddr[5:2]]};
    end else begin
      case (araddr)
        SCCU_CTRL: rd_d = {23'h000000, ctrl_q};
        SCCU_TMR0: rd_d = {16'h0000, tmr_q[0]};
        SCCU_RLD0: rd_d = {16'h0000, rld_q[0]};
        SCCU_TMR1: rd_d = {16'h0000, tmr_q[1]};
        SCCU_RLD1: rd_d = {16'h0000, rld_q[1]};
        SCCU_STAT: rd_d = {14'h0000, st_q};
        SCCU_MASK: rd_d = {14'h0000, mask_q};
        SCCU_PINS: rd_d = {cc_pin_i, cc_pin_o};
        default: rd_ok = 1'b0;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rresp_q <= SCCU_OKAY;
      rdata_q <= '0;
    end else if (arvalid && arready) begin
      rvalid_q <= 1'b1;
      rresp_q <= rd_ok ? SCCU_OKAY : SCCU_SLVERR;
      rdata_q <= rd_d;
    end else if (rvalid_q && rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ==========================================================
  // Control, prescaler, stagger slot
  wire [31:0] wm_ctrl = strb_merge({23'h000000, ctrl_q}, wdata_q, wstrb_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= SCCU_CTRL_RST;
      pre_q <= '0;
      stag_q <= '0;
      ecnt_prev_q <= '0;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= wm_ctrl[SCCU_CTRL_W-1:0];
      end
      pre_q <= pre_q + 1'b1;
      stag_q <= stag_q + 1'b1;
      ecnt_prev_q <= ext_cnt_i;
    end
  end

  // ==========================================================
  // Timers
  for (genvar t = 0; t < 2; t++) begin : g_tmr
    wire [2:0] sel = ctrl_q[SCCU_CTRL_SEL0 + t*SCCU_SEL_W +: SCCU_SEL_W];
    wire run = ctrl_q[SCCU_CTRL_RUN0 + t];
    wire [SCCU_PRE_W-1:0] pmask = SCCU_PRE_W'((5'h01 << sel) - 5'h01);
    wire div_tick = (pre_q & pmask) == pmask;
    wire ext_edge = ext_cnt_i[t] && !ecnt_prev_q[t];
    wire [31:0] wm_tmr = strb_merge({16'h0000, tmr_q[t]}, wdata_q, wstrb_q);
    wire [31:0] wm_rld = strb_merge({16'h0000, rld_q[t]}, wdata_q, wstrb_q);

    assign tick[t] = run && ((sel <= SCCU_CLK_MAXDIV) ? div_tick :
                             (sel == SCCU_CLK_EXT_OVF) ? ext_ovf_i :
                             (sel == SCCU_CLK_EXT_IN) ? ext_edge : 1'b0);
    assign ovf[t] = tick[t] && (tmr_q[t] == SCCU_TMR_MAX);

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        tmr_q[t] <= '0;
        rld_q[t] <= SCCU_RLD_RST;
      end else begin
        if (wr_tmr[t]) begin
          tmr_q[t] <= wm_tmr[SCCU_TW-1:0];
        end else if (ovf[t]) begin
          tmr_q[t] <= rld_q[t];
        end else if (tick[t]) begin
          tmr_q[t] <= tmr_q[t] + 1'b1;
        end
        if (wr_rld[t]) begin
          rld_q[t] <= wm_rld[SCCU_TW-1:0];
        end
      end
    end
  end

  // ==========================================================
  // Channels
  for (genvar i = 0; i < SCCU_NCH; i++) begin : g_ch
    wire sccu_mode_t mode = cfg_q[i].mode;
    wire [SCCU_TW-1:0] tv = cfg_q[i].tsel ? tmr_q[1] : tmr_q[0];
    wire tovf = cfg_q[i].tsel ? ovf[1] : ovf[0];
    wire slot = !ctrl_q[SCCU_CTRL_STAG] || (stag_q == SCCU_STAG_W'(i));
    wire is_cmp = mode inside {SCCU_CMP0, SCCU_CMP1, SCCU_CMP2, SCCU_CMP3, SCCU_DBL};
    wire once = mode inside {SCCU_CMP2, SCCU_CMP3};
    wire m_own = val_q[i] == tv;
    wire m_pair = (mode == SCCU_DBL) && (val_q[i ^ SCCU_PAIR] == tv);
    wire hit = slot && is_cmp && !done_q[i] && (m_own || m_pair);
    wire rise = cc_pin_i[i] && !prev_q[i];
    wire fall = !cc_pin_i[i] && prev_q[i];
    wire cap = (mode == SCCU_CAP) &&
               ((cfg_q[i].edge_sel[SCCU_EDGE_RISE] && rise) || (cfg_q[i].edge_sel[SCCU_EDGE_FALL] && fall));
    wire [31:0] wm_val = strb_merge({16'h0000, val_q[i]}, wdata_q, wstrb_q);
    wire [31:0] wm_cfg = strb_merge({25'h0000000, cfg_q[i]}, wdata_q, wstrb_q);

    // Every compare event and capture is an interrupt request
    assign ch_ev[i] = hit || cap;
    assign cc_pin_o[i] = pin_q[i];
    assign cc_pin_oe[i] = mode inside {SCCU_CMP1, SCCU_CMP3, SCCU_DBL};

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        val_q[i] <= '0;
        cfg_q[i] <= '0;
        pin_q[i] <= 1'b0;
        done_q[i] <= 1'b0;
        prev_q[i] <= 1'b0;
      end else begin
        prev_q[i] <= cc_pin_i[i];
        // Capture beats a software write to the same value word
        if (cap) begin
          val_q[i] <= tv;
        end else if (wr_val_pg && widx == 4'(i)) begin
          val_q[i] <= wm_val[SCCU_TW-1:0];
        end
        if (wr_cfg_pg && widx == 4'(i)) begin
          cfg_q[i] <= sccu_cfg_t'(wm_cfg[SCCU_CFG_W-1:0]);
        end else if (hit && cfg_q[i].single) begin
          cfg_q[i].mode <= SCCU_OFF;
        end
        if (wr_cfg_pg && widx == 4'(i)) begin
          done_q[i] <= 1'b0;
        end else if (hit && once) begin
          done_q[i] <= 1'b1;
        end else if (tovf) begin
          done_q[i] <= 1'b0;
        end
        if (hit && (mode == SCCU_CMP1 || mode == SCCU_DBL)) begin
          pin_q[i] <= !pin_q[i];
        end else if (hit && mode == SCCU_CMP3) begin
          pin_q[i] <= 1'b1;
        end else if (tovf && mode == SCCU_CMP3) begin
          pin_q[i] <= 1'b0;
        end
      end
    end
  end

  // ==========================================================
  // Interrupt status: a new event wins over a write-one clear
  wire [SCCU_ST_W-1:0] st_set = {ovf, ch_ev};
  wire [31:0] wm_clr = strb_merge(32'h00000000, wdata_q, wstrb_q);
  wire [SCCU_ST_W-1:0] st_clr = wr_stat ? wm_clr[SCCU_ST_W-1:0] : '0;
  wire [31:0] wm_mask = strb_merge({14'h0000, mask_q}, wdata_q, wstrb_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= '0;
      mask_q <= '0;
    end else begin
      st_q <= (st_q & ~st_clr) | st_set;
      if (wr_mask) begin
        mask_q <= wm_mask[SCCU_ST_W-1:0];
      end
    end
  end

  assign irq = |(st_q & mask_q);

endmodule : sccu_top

// ---- sim/sccu_chk.sv ----
`timescale 1ns/1ps
module sccu_chk
  import sccu_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus
  input wire logic awvalid, awready, wvalid, wready, bvalid, bready,
  input wire logic [1:0] bresp,
  input wire logic arvalid, arready, rvalid, rready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  // Pins and interrupt
  input wire logic [SCCU_NCH-1:0] cc_pin_o,
  input wire logic [SCCU_NCH-1:0] cc_pin_oe,
  input wire logic irq
);
  // ========
  // Properties
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_b_hold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
  property p_r_hold; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped early");
  property p_ar_rdy; arready == !rvalid; endproperty
  a_ar_rdy: assert property (p_ar_rdy) else $error("arready wrong");
  property p_aw_rdy; bvalid |-> !awready && !wready; endproperty
  a_aw_rdy: assert property (p_aw_rdy) else $error("write taken during response");
  property p_wr_lat; awvalid && awready && wvalid && wready |-> ##2 bvalid; endproperty
  a_wr_lat: assert property (p_wr_lat) else $error("write response late");
  property p_rd_lat; arvalid && arready |=> rvalid ##0 (rresp != SCCU_SLVERR || rdata == 32'h0); endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer late or dirty");
  // Undriven pins must never move, so interrupt-only modes leave them alone
  property p_pin_drv; (|((cc_pin_o ^ $past(cc_pin_o)) & ~$past(cc_pin_oe))) == 1'b0; endproperty
  a_pin_drv: assert property (p_pin_drv) else $error("undriven pin changed");
  property p_irq_stick; $fell(irq) |-> $rose(bvalid); endproperty
  a_irq_stick: assert property (p_irq_stick) else $error("irq fell without a write");
  c_err: cover property (bvalid && bresp == SCCU_SLVERR);
  c_irq: cover property ($rose(irq));
  c_m3: cover property (cc_pin_oe[3] && $fell(cc_pin_o[3]));
endmodule : sccu_chk

// ---- sim/sccu_pins_model.sv ----
`timescale 1ns/1ps
module sccu_pins_model (
  // Clock
  input wire logic aclk,
  // Far side signals
  output logic [15:0] pin,
  output logic ovf,
  output logic [1:0] cnt
);
  initial begin
    pin = 16'h0;
    ovf = 1'b0;
    cnt = 2'h0;
  end
  // Level on a channel pin, changed just after an edge
  task drive(input int ch, input logic lv);
    pin[ch] <= lv;
    @(posedge aclk);
  endtask : drive
  // One-cycle overflow pulse of the other timer module
  task pulse_ovf;
    ovf <= 1'b1;
    @(posedge aclk);
    ovf <= 1'b0;
    repeat (2) @(posedge aclk);
  endtask : pulse_ovf
  task rise(input int t);
    cnt[t] <= 1'b1;
    repeat (2) @(posedge aclk);
    cnt[t] <= 1'b0;
    repeat (2) @(posedge aclk);
  endtask : rise
endmodule : sccu_pins_model

// ---- sim/tb.sv ----
`timescale 1ns/1ps
module tb;
  import sccu_pkg::*;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 1, arvalid = 0, rready = 1;
  logic awready, wready, bvalid, arready, rvalid, irq, ovf;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, v;
  logic [1:0] bresp, rresp, r, cnt;
  logic [15:0] pin_i, pin_o, pin_oe;
  int failures = 0, compares = 0, cyc = 0;
  initial forever #5 aclk = ~aclk;
  sccu_top sccu_top_i (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hf), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid),
    .rready(rready), .rdata(rdata), .rresp(rresp), .cc_pin_i(pin_i), .cc_pin_o(pin_o), .cc_pin_oe(pin_oe),
    .ext_ovf_i(ovf), .ext_cnt_i(cnt), .irq(irq));
  sccu_pins_model sccu_pins_model_i (.aclk(aclk), .pin(pin_i), .ovf(ovf), .cnt(cnt));
  // ========
  // Bus and compare helpers
  task chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      failures++;
      $display("unexpected at %0t: got %h, expected %h", $time, s, e);
    end
  endtask : chk
  // Ready and answers are judged at the rising edge that takes them
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic sb;
    sb = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    while (!sb) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
      sb = bvalid;
      r = bresp;
    end
  endtask : wr
  task rd(input logic [7:0] a);
    logic sr;
    sr = 0;
    araddr <= a;
    arvalid <= 1;
    while (!sr) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 0;
      sr = rvalid;
      v = rdata;
      r = rresp;
    end
  endtask : rd
  task tog(input int ch, input int n, input int e);
    int c;
    logic p;
    c = 0;
    @(negedge aclk);
    p = pin_o[ch];
    repeat (n) begin
      @(negedge aclk);
      if (pin_o[ch] !== p) c++;
      p = pin_o[ch];
    end
    chk(32'(c), 32'(e));
    @(posedge aclk);
  endtask : tog
  task wt(input int ch, input logic lv);
    int n;
    n = 0;
    while (pin_o[ch] !== lv && n < 40) begin
      @(negedge aclk);
      n++;
    end
    chk({31'h0, pin_o[ch]}, {31'h0, lv});
    @(posedge aclk);
  endtask : wt
  // ========
  // Scenarios
  task t_regs;
    rd(SCCU_CTRL);
    chk(v, 32'h0);
    wr(SCCU_RLD1, 32'h0001abcd);
    rd(SCCU_RLD1);
    chk(v, 32'h0000abcd);
    wr(8'h20, 32'h1);
    chk({30'h0, r}, {30'h0, SCCU_SLVERR});
    rd(8'h20);
    chk({r, v[29:0]}, {SCCU_SLVERR, 30'h0});
    $display("t_regs done");
  endtask : t_regs
  task t_cap;
    wr(SCCU_TMR0, 32'h1234);
    wr(SCCU_TMR1, 32'h0abc);
    wr(8'h80, 32'h09);
    wr(8'h84, 32'h31);
    sccu_pins_model_i.drive(0, 1);
    sccu_pins_model_i.drive(1, 1);
    repeat (3) @(posedge aclk);
    rd(8'h44);
    chk(v, 32'h0);
    rd(8'h40);
    chk(v, 32'h1234);
    sccu_pins_model_i.drive(1, 0);
    repeat (3) @(posedge aclk);
    rd(8'h44);
    chk(v, 32'h0abc);
    rd(SCCU_STAT);
    chk(v, 32'h3);
    wr(SCCU_MASK, 32'h1);
    chk({31'h0, irq}, 32'h1);
    wr(SCCU_STAT, 32'h1);
    chk({31'h0, irq}, 32'h0);
    wr(SCCU_MASK, 32'h0);
    $display("t_cap done");
  endtask : t_cap
  task t_once;
    logic p;
    wr(SCCU_TMR0, 32'h0100);
    for (int i = 8; i < 12; i++) wr(8'h40 + 8'(4 * i), 32'h0100);
    wr(8'ha0, 32'h04);
    wr(8'ha4, 32'h02);
    wr(8'ha8, 32'h43);
    wr(8'hac, 32'h03);
    @(negedge aclk);
    p = pin_o[11];
    @(negedge aclk);
    chk({31'h0, pin_o[11]}, {31'h0, ~p});
    chk({30'h0, pin_oe[10], pin_o[10]}, 32'h1);
    @(posedge aclk);
    wr(SCCU_STAT, 32'h300);
    repeat (4) @(posedge aclk);
    rd(SCCU_STAT);
    chk(v & 32'h300, 32'h200);
    $display("t_once done");
  endtask : t_once
  task t_run;
    wr(SCCU_RLD0, 32'hfff0);
    wr(SCCU_TMR0, 32'hfff0);
    wr(8'h4c, 32'hfff8);
    wr(8'h8c, 32'h05);
    wr(8'h54, 32'hfff8);
    wr(8'h94, 32'h02);
    wr(8'h58, 32'hfff2);
    wr(8'h78, 32'hfffa);
    wr(8'h98, 32'h06);
    wr(8'h5c, 32'hfff4);
    wr(8'h9c, 32'h03);
    wr(SCCU_STAT, 32'h3ffff);
    wr(SCCU_CTRL, 32'h1);
    tog(6, 32, 4);
    tog(7, 32, 2);
    wt(3, 1);
    wt(3, 0);
    chk({29'h0, pin_oe[5], pin_o[5], pin_oe[3]}, 32'h1);
    rd(SCCU_STAT);
    chk(v & 32'h10020, 32'h10020);
    rd(SCCU_TMR0);
    chk({4'h0, v[31:4]}, 32'h0fff);
    $display("t_run done");
  endtask : t_run
  task t_ext;
    wr(SCCU_CTRL, 32'h10d);
    tog(6, 256, 4);
    wr(SCCU_CTRL, 32'ha2);
    wr(SCCU_TMR1, 32'h0);
    repeat (3) sccu_pins_model_i.pulse_ovf;
    rd(SCCU_TMR1);
    chk(v, 32'h3);
    wr(SCCU_CTRL, 32'hc2);
    repeat (2) sccu_pins_model_i.rise(1);
    rd(SCCU_TMR1);
    chk(v, 32'h5);
    $display("t_ext done");
  endtask : t_ext
  task test_done;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : test_done
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    t_regs;
    t_cap;
    t_once;
    t_run;
    t_ext;
    test_done;
  end
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      test_done;
    end
  end
endmodule : tb
bind sccu_top sccu_chk sccu_chk_i (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
  .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
  .arready(arready), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .cc_pin_o(cc_pin_o),
  .cc_pin_oe(cc_pin_oe), .irq(irq));
